// ==== mdp_pins.sv ====
// =============================================================
// board model: resolves the four port pin levels
// assumes ports packed {fourth, third, second, first}, 8 bits each
// =============================================================
module mdp_pins
    import mdp_pkg::*;
(
    input wire logic clk_in,
    input wire logic [31:0] oe_in,
    input wire logic [31:0] drive_in,
    input wire logic [31:0] ext_in,
    input wire logic [31:0] ext_en_in,
    output logic [31:0] pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_q = 8'h5A;

    // undriven lines wander, except the third port's pulled-up ones, so a stale level is never mistaken for data
    always_ff @(posedge clk_in) begin
        float_q <= ~float_q;
    end

    // device drive wins; board drives on reads; third port has a pull-up
    assign pin_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_in)
        | (~oe_in & ~ext_en_in & {float_q, 8'hFF, float_q, float_q});
endmodule // mdp_pins

// ==== mdp_pkg.sv ====
// =============================================================
// constants, types and helpers of the mode-dependent ports
// assumes one 100 MHz clock and a synchronous active-high reset
// =============================================================
// Functional notes
// - mode pins sampled in reset pick mode
// - single-chip/bootstrap: bit7 of fourth port general
// - expanded/test: bit7 high on read, low write
// - expanded/test: bit6 is address strobe
// - first port reads pin or driver level
// - first port writes latch, drive only outputs
// - output compare owns pin, writes ignored
// - reset: bits 6:4 drive low, others input
// - control register directions rule bits 7, 3
// - expanded: second port drives address 15:8
// - second port latch drives only in general modes
// - reset: second port input or high address
// - expanded: third port drives address 7:0
// - data phase direction follows read/write
// - third port latch drives only in general modes
// - reset: third port input or address/data
// - open-drain bit kills all pull-ups together
// - open-drain: zero pulls low, one floats
// - open-drain only in single-chip mode
// - fourth port read-back and latched writes
// - serial subsystems take over their fourth-port bits
// - expanded/test: bits 6, 7 not general
package mdp_pkg;

    // =========================================================
    // operating modes, one-hot
    typedef enum logic [3:0] {
        MDP_SINGLE = 4'h1,
        MDP_EXPANDED = 4'h2,
        MDP_BOOT = 4'h4,
        MDP_TEST = 4'h8
    } mdp_mode_t;

    // =========================================================
    // write strobe index of each port register
    localparam int REG_CNT = 9;
    localparam int REG_FIRST_DATA = 0;
    localparam int REG_PULSE_ACCUM = 1;
    localparam int REG_SECOND_DATA = 2;
    localparam int REG_SECOND_DIR = 3;
    localparam int REG_THIRD_DATA = 4;
    localparam int REG_THIRD_DIR = 5;
    localparam int REG_FOURTH_DATA = 6;
    localparam int REG_FOURTH_DIR = 7;
    localparam int REG_PIO_CTRL = 8;

    // =========================================================
    // field positions
    localparam int PULSE_ACCUM_DIR7_BIT = 7;
    localparam int PULSE_ACCUM_DIR3_BIT = 3;
    localparam int PIO_CTRL_OPEN_DRAIN_BIT = 5;
    localparam int DIR_BIT = 7;
    localparam int STROBE_BIT = 6;

    // =========================================================
    // reset values and fixed pin roles
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FIRST_FIXED_OUT = 8'h70;
    localparam logic [7:0] FIRST_OC_MASK = 8'hF8;

    // mode pin pair {b,a} to operating mode
    function automatic mdp_mode_t mdp_decode(input logic b, input logic a);
        mdp_mode_t m;
        m = MDP_SINGLE;
        unique case ({b, a})
            2'b00: m = MDP_BOOT;
            2'b01: m = MDP_TEST;
            2'b10: m = MDP_SINGLE;
            2'b11: m = MDP_EXPANDED;
        endcase
        return m;
    endfunction

    // read-back: driver input when driving, else pin level
    function automatic logic [7:0] mdp_readback(input logic [7:0] oe,
        input logic [7:0] drv, input logic [7:0] pin);
        return (oe & drv) | (~oe & pin);
    endfunction

endpackage

// ==== mdp_ports.sv ====
// =============================================================
// four 8-bit parallel ports with mode-dependent pin roles
// assumes pins are resolved by the bench from out and oe;
// register writes arrive as strobes on the same clock
// =============================================================
module mdp_ports
    import mdp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic mode_select_a_in,
    input wire logic mode_select_b_in,
    input wire logic [REG_CNT-1:0] reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [15:0] bus_addr_in,
    input wire logic [7:0] bus_wdata_in,
    input wire logic bus_read_in,
    input wire logic bus_addr_phase_in,
    output logic [7:0] bus_rdata_out,
    input wire logic [7:0] timer_oc_en_in,
    input wire logic [7:0] timer_oc_level_in,
    input wire logic [5:0] serial_en_in,
    input wire logic [5:0] serial_oe_in,
    input wire logic [5:0] serial_level_in,
    input wire logic [7:0] first_port_pin_in,
    output logic [7:0] first_port_pin_out,
    output logic [7:0] first_port_pin_oe_out,
    output logic [7:0] first_port_data_out,
    input wire logic [7:0] second_port_pin_in,
    output logic [7:0] second_port_pin_out,
    output logic [7:0] second_port_pin_oe_out,
    output logic [7:0] second_port_data_out,
    input wire logic [7:0] third_port_pin_in,
    output logic [7:0] third_port_pin_out,
    output logic [7:0] third_port_pin_oe_out,
    output logic [7:0] third_port_data_out,
    input wire logic [7:0] fourth_port_pin_in,
    output logic [7:0] fourth_port_pin_out,
    output logic [7:0] fourth_port_pin_oe_out,
    output logic [7:0] fourth_port_data_out,
    output logic [3:0] mode_out
);

    // =========================================================
    // pin synchronisers
    logic [33:0] sync_w;
    logic [7:0] pa_s;
    logic [7:0] pb_s;
    logic [7:0] pc_s;
    logic [7:0] pd_s;
    logic mode_a_s;
    logic mode_b_s;

    // one bank for all pins keeps the crossing in one place
    mdp_sync #(
        .WIDTH(34)
    ) u_sync (
        .clk_in(clk_in),
        .async_in({mode_select_b_in, mode_select_a_in,
            fourth_port_pin_in, third_port_pin_in,
            second_port_pin_in, first_port_pin_in}),
        .sync_out(sync_w)
    );

    assign pa_s = sync_w[7:0];
    assign pb_s = sync_w[15:8];
    assign pc_s = sync_w[23:16];
    assign pd_s = sync_w[31:24];
    assign mode_a_s = sync_w[32];
    assign mode_b_s = sync_w[33];

    // =========================================================
    // operating mode
    mdp_mode_t mode_q;
    mdp_mode_t mode_d;
    logic gen_mode;
    logic ext_mode;

    // sampled every reset cycle, frozen after release
    always_comb begin
        mode_d = mode_q;
        if (rst_in) begin
            mode_d = mdp_decode(mode_b_s, mode_a_s);
        end
    end

    always_ff @(posedge clk_in) begin
        mode_q <= mode_d;
    end

    assign gen_mode = (mode_q == MDP_SINGLE) || (mode_q == MDP_BOOT);
    assign ext_mode = (mode_q == MDP_EXPANDED) || (mode_q == MDP_TEST);
    assign mode_out = mode_q;

    // =========================================================
    // data latches, direction and control registers
    logic [7:0] a_data_q, a_data_d;
    logic [7:0] pulse_accum_q, pulse_accum_d;
    logic [7:0] b_data_q, b_data_d;
    logic [7:0] b_dir_q, b_dir_d;
    logic [7:0] c_data_q, c_data_d;
    logic [7:0] c_dir_q, c_dir_d;
    logic [7:0] d_data_q, d_data_d;
    logic [7:0] d_dir_q, d_dir_d;
    logic [7:0] pio_ctrl_q, pio_ctrl_d;

    // latches always take writes; the pin mux decides use
    always_comb begin
        a_data_d = a_data_q;
        pulse_accum_d = pulse_accum_q;
        b_data_d = b_data_q;
        b_dir_d = b_dir_q;
        c_data_d = c_data_q;
        c_dir_d = c_dir_q;
        d_data_d = d_data_q;
        d_dir_d = d_dir_q;
        pio_ctrl_d = pio_ctrl_q;
        if (reg_wr_in[REG_FIRST_DATA]) begin
            a_data_d = reg_wdata_in;
        end
        if (reg_wr_in[REG_PULSE_ACCUM]) begin
            pulse_accum_d = reg_wdata_in;
        end
        if (reg_wr_in[REG_SECOND_DATA]) begin
            b_data_d = reg_wdata_in;
        end
        if (reg_wr_in[REG_SECOND_DIR]) begin
            b_dir_d = reg_wdata_in;
        end
        if (reg_wr_in[REG_THIRD_DATA]) begin
            c_data_d = reg_wdata_in;
        end
        if (reg_wr_in[REG_THIRD_DIR]) begin
            c_dir_d = reg_wdata_in;
        end
        if (reg_wr_in[REG_FOURTH_DATA]) begin
            d_data_d = reg_wdata_in;
        end
        if (reg_wr_in[REG_FOURTH_DIR]) begin
            d_dir_d = reg_wdata_in;
        end
        if (reg_wr_in[REG_PIO_CTRL]) begin
            pio_ctrl_d = reg_wdata_in;
        end
    end

    // reset leaves every general pin an input, latches low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            a_data_q <= DATA_RESET;
            pulse_accum_q <= CTRL_RESET;
            b_data_q <= DATA_RESET;
            b_dir_q <= DIR_RESET;
            c_data_q <= DATA_RESET;
            c_dir_q <= DIR_RESET;
            d_data_q <= DATA_RESET;
            d_dir_q <= DIR_RESET;
            pio_ctrl_q <= CTRL_RESET;
        end else begin
            a_data_q <= a_data_d;
            pulse_accum_q <= pulse_accum_d;
            b_data_q <= b_data_d;
            b_dir_q <= b_dir_d;
            c_data_q <= c_data_d;
            c_dir_q <= c_dir_d;
            d_data_q <= d_data_d;
            d_dir_q <= d_dir_d;
            pio_ctrl_q <= pio_ctrl_d;
        end
    end

    // =========================================================
    // pin multiplexers
    logic [7:0] a_out_q, a_out_d, a_oe_q, a_oe_d;
    logic [7:0] b_out_q, b_out_d, b_oe_q, b_oe_d;
    logic [7:0] c_out_q, c_out_d, c_oe_q, c_oe_d;
    logic [7:0] d_out_q, d_out_d, d_oe_q, d_oe_d;
    logic [7:0] a_oc;
    logic od_on;

    assign a_oc = timer_oc_en_in & FIRST_OC_MASK;
    // open drain honoured in single-chip only
    assign od_on = pio_ctrl_q[PIO_CTRL_OPEN_DRAIN_BIT] && (mode_q == MDP_SINGLE);

    // general directions first, alternate functions override them last
    always_comb begin
        // first port: fixed outputs, two steerable bits
        a_oe_d = FIRST_FIXED_OUT;
        a_oe_d[7] = pulse_accum_q[PULSE_ACCUM_DIR7_BIT];
        a_oe_d[3] = pulse_accum_q[PULSE_ACCUM_DIR3_BIT];
        a_oe_d = a_oe_d | a_oc;
        // compare-owned bits ignore the latch
        a_out_d = (a_oc & timer_oc_level_in) | (~a_oc & a_data_q);
        // second port
        if (ext_mode) begin
            b_oe_d = 8'hFF;
            b_out_d = bus_addr_in[15:8];
        end else begin
            b_oe_d = b_dir_q;
            b_out_d = b_data_q;
        end
        // third port
        if (ext_mode) begin
            if (bus_addr_phase_in) begin
                c_oe_d = 8'hFF;
                c_out_d = bus_addr_in[7:0];
            end else begin
                c_oe_d = {8{~bus_read_in}};
                c_out_d = bus_wdata_in;
            end
        end else if (od_on) begin
            // only the pull-down acts: drive low or float
            c_oe_d = c_dir_q & ~c_data_q;
            c_out_d = 8'h00;
        end else begin
            c_oe_d = c_dir_q;
            c_out_d = c_data_q;
        end
        // fourth port: serial bits, then bus control bits
        d_oe_d = d_dir_q;
        d_out_d = d_data_q;
        for (int i = 0; i < 6; i++) begin
            if (serial_en_in[i]) begin
                d_oe_d[i] = serial_oe_in[i];
                d_out_d[i] = serial_level_in[i];
            end
        end
        if (ext_mode) begin
            d_oe_d[DIR_BIT] = 1'b1;
            d_out_d[DIR_BIT] = bus_read_in;
            d_oe_d[STROBE_BIT] = 1'b1;
            d_out_d[STROBE_BIT] = bus_addr_phase_in;
        end
    end

    // pins idle as inputs while reset is held, except first port bits 6:4, which drive low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            a_oe_q <= FIRST_FIXED_OUT;
            a_out_q <= DATA_RESET;
            b_oe_q <= DIR_RESET;
            b_out_q <= DATA_RESET;
            c_oe_q <= DIR_RESET;
            c_out_q <= DATA_RESET;
            d_oe_q <= DIR_RESET;
            d_out_q <= DATA_RESET;
        end else begin
            a_oe_q <= a_oe_d;
            a_out_q <= a_out_d;
            b_oe_q <= b_oe_d;
            b_out_q <= b_out_d;
            c_oe_q <= c_oe_d;
            c_out_q <= c_out_d;
            d_oe_q <= d_oe_d;
            d_out_q <= d_out_d;
        end
    end

    assign first_port_pin_out = a_out_q;
    assign first_port_pin_oe_out = a_oe_q;
    assign second_port_pin_out = b_out_q;
    assign second_port_pin_oe_out = b_oe_q;
    assign third_port_pin_out = c_out_q;
    assign third_port_pin_oe_out = c_oe_q;
    assign fourth_port_pin_out = d_out_q;
    assign fourth_port_pin_oe_out = d_oe_q;

    // =========================================================
    // read-back registers
    logic [7:0] ra_q, ra_d, rb_q, rb_d, rc_q, rc_d, rd_q, rd_d;
    logic [7:0] bus_rd_q, bus_rd_d;

    // reads of floating open-drain bits see the pin
    always_comb begin
        ra_d = mdp_readback(a_oe_q, a_out_q, pa_s);
        rb_d = mdp_readback(b_oe_q, b_out_q, pb_s);
        rc_d = mdp_readback(c_oe_q, c_out_q, pc_s);
        rd_d = mdp_readback(d_oe_q, d_out_q, pd_s);
        bus_rd_d = pc_s;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ra_q <= DATA_RESET;
            rb_q <= DATA_RESET;
            rc_q <= DATA_RESET;
            rd_q <= DATA_RESET;
            bus_rd_q <= DATA_RESET;
        end else begin
            ra_q <= ra_d;
            rb_q <= rb_d;
            rc_q <= rc_d;
            rd_q <= rd_d;
            bus_rd_q <= bus_rd_d;
        end
    end

    assign first_port_data_out = ra_q;
    assign second_port_data_out = rb_q;
    assign third_port_data_out = rc_q;
    assign fourth_port_data_out = rd_q;
    assign bus_rdata_out = bus_rd_q;

    // =========================================================
    // assertions
    sequence s_ext_read;
        ext_mode && !bus_addr_phase_in && bus_read_in;
    endsequence

    sequence s_ext_addr;
        ext_mode && bus_addr_phase_in;
    endsequence

    property p_mode_frozen;
        @(posedge clk_in) disable iff (rst_in) $stable(mode_q);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen)
        else $error("mode changed outside reset");

    property p_dir_pin;
        @(posedge clk_in) disable iff (rst_in)
            s_ext_read |=> d_oe_q[DIR_BIT] && d_out_q[DIR_BIT];
    endproperty
    a_dir_pin: assert property (p_dir_pin)
        else $error("direction pin not high on read");

    property p_strobe;
        @(posedge clk_in) disable iff (rst_in)
            s_ext_addr |=> d_out_q[STROBE_BIT] && d_oe_q[STROBE_BIT];
    endproperty
    a_strobe: assert property (p_strobe)
        else $error("address strobe missing");

    property p_reset_first;
        @(posedge clk_in) rst_in ##1 !rst_in && timer_oc_en_in == 8'h00
            |=> a_oe_q == FIRST_FIXED_OUT && a_out_q[6:4] == 3'b000;
    endproperty
    a_reset_first: assert property (p_reset_first)
        else $error("first port reset state wrong");

    property p_oc_owns;
        @(posedge clk_in) disable iff (rst_in)
            a_oc[5] && reg_wr_in[REG_FIRST_DATA]
            |=> a_out_q[5] == $past(timer_oc_level_in[5]);
    endproperty
    a_oc_owns: assert property (p_oc_owns)
        else $error("write overrode compare pin");

    property p_high_addr;
        @(posedge clk_in) disable iff (rst_in)
            mode_q == MDP_EXPANDED
            |=> b_oe_q == 8'hFF && b_out_q == $past(bus_addr_in[15:8]);
    endproperty
    a_high_addr: assert property (p_high_addr)
        else $error("high address not on second port");

    property p_low_addr;
        @(posedge clk_in) disable iff (rst_in)
            s_ext_addr |=> c_oe_q == 8'hFF && c_out_q == $past(bus_addr_in[7:0]);
    endproperty
    a_low_addr: assert property (p_low_addr)
        else $error("low address not on third port");

    property p_data_dir;
        @(posedge clk_in) disable iff (rst_in)
            s_ext_read |=> c_oe_q == 8'h00;
    endproperty
    a_data_dir: assert property (p_data_dir)
        else $error("third port driven during read");

    property p_open_drain;
        @(posedge clk_in) disable iff (rst_in)
            od_on && !ext_mode
            |=> c_out_q == 8'h00 && c_oe_q == $past(c_dir_q & ~c_data_q);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain drive wrong");

    property p_gen_bit7;
        @(posedge clk_in) disable iff (rst_in)
            gen_mode |=> d_oe_q[DIR_BIT] == $past(d_dir_q[DIR_BIT]);
    endproperty
    a_gen_bit7: assert property (p_gen_bit7)
        else $error("bit 7 not general in single-chip");

endmodule // mdp_ports

// ==== mdp_sync.sv ====
// =============================================================
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous to clk_in
// =============================================================
module mdp_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // no reset: pure data path, settles in two edges
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_in) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_out = sync_q;

endmodule // mdp_sync

// ==== tb_top.sv ====
// =============================================================
// self-checking bench for the mode-dependent ports
// assumes mdp_pkg, mdp_ports and the board model mdp_pins
// =============================================================
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mdp_pkg::*;

    typedef struct {
        int id;
        logic [7:0] exp;
        logic [7:0] msk;
    } mdp_note_t;

    logic clk_in = 1'h0;
    logic rst_in = 1'h1;
    logic mode_a = 1'h0;
    logic mode_b = 1'h1;
    logic [REG_CNT-1:0] reg_wr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic rd = 1'h0;
    logic aph = 1'h0;
    logic [7:0] oc_en = 8'h00;
    logic [7:0] oc_lvl = 8'h00;
    logic [5:0] ser_en = 6'h00;
    logic [5:0] ser_oe = 6'h00;
    logic [5:0] ser_lvl = 6'h00;
    logic [31:0] ext = 32'h00000000;
    logic [31:0] ext_en = 32'hFFFFFFFF;
    logic [31:0] rs = 32'h0000000B;
    wire [31:0] pin;
    wire [31:0] drv;
    wire [31:0] oe;
    wire [31:0] dat;
    wire [7:0] rdata;
    wire [3:0] mode;
    mdp_note_t q[$];
    mdp_note_t nt;
    int errors = 0;
    int n_compared = 0;
    event chk_ev;

    // =========================================================
    // clock, design and board
    always #5 clk_in = ~clk_in;

    mdp_ports mdp_ports_inst (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .mode_select_a_in(mode_a),
        .mode_select_b_in(mode_b),
        .reg_wr_in(reg_wr),
        .reg_wdata_in(reg_wdata),
        .bus_addr_in(addr),
        .bus_wdata_in(wdata),
        .bus_read_in(rd),
        .bus_addr_phase_in(aph),
        .bus_rdata_out(rdata),
        .timer_oc_en_in(oc_en),
        .timer_oc_level_in(oc_lvl),
        .serial_en_in(ser_en),
        .serial_oe_in(ser_oe),
        .serial_level_in(ser_lvl),
        .first_port_pin_in(pin[7:0]),
        .first_port_pin_out(drv[7:0]),
        .first_port_pin_oe_out(oe[7:0]),
        .first_port_data_out(dat[7:0]),
        .second_port_pin_in(pin[15:8]),
        .second_port_pin_out(drv[15:8]),
        .second_port_pin_oe_out(oe[15:8]),
        .second_port_data_out(dat[15:8]),
        .third_port_pin_in(pin[23:16]),
        .third_port_pin_out(drv[23:16]),
        .third_port_pin_oe_out(oe[23:16]),
        .third_port_data_out(dat[23:16]),
        .fourth_port_pin_in(pin[31:24]),
        .fourth_port_pin_out(drv[31:24]),
        .fourth_port_pin_oe_out(oe[31:24]),
        .fourth_port_data_out(dat[31:24]),
        .mode_out(mode)
    );

    mdp_pins mdp_pins_inst (
        .clk_in(clk_in),
        .oe_in(oe),
        .drive_in(drv),
        .ext_in(ext),
        .ext_en_in(ext_en),
        .pin_out(pin)
    );

    // =========================================================
    // helpers
    // id = 3 * port + kind (out, oe, data); 12 read data, 13 mode
    function automatic logic [7:0] seen(input int id);
        if (id == 12) return rdata;
        if (id == 13) return {4'h0, mode};
        case (id % 3)
            0: return drv[id / 3 * 8 +: 8];
            1: return oe[id / 3 * 8 +: 8];
            default: return dat[id / 3 * 8 +: 8];
        endcase
    endfunction

    function automatic string name_of(input int id);
        string k[3] = '{"out", "oe", "data"};
        if (id > 11) return (id == 12) ? "rdata" : "mode";
        return $sformatf("port%0d_%s", id / 3 + 1, k[id % 3]);
    endfunction

    function automatic void rnd(output logic [7:0] v);
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        v = rs[7:0];
    endfunction

    task automatic note(input int id, input logic [7:0] e, input logic [7:0] m);
        q.push_back('{id, e, m});
    endtask

    task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask

    // fixed wait covers latch, pin and synchroniser latency
    task automatic settle();
        repeat (6) @(posedge clk_in);
        #1;
        -> chk_ev;
    endtask

    // strobe held one cycle; calls may follow back to back
    task automatic wr(input int idx, input logic [7:0] v);
        @(posedge clk_in);
        reg_wr <= REG_CNT'(1) << idx;
        reg_wdata <= v;
    endtask

    task automatic idle();
        @(posedge clk_in);
        reg_wr <= '0;
    endtask

    task automatic do_reset(input logic b, input logic a);
        @(posedge clk_in);
        rst_in <= 1'h1;
        mode_b <= b;
        mode_a <= a;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'h0;
    endtask

    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // =========================================================
    // monitor: every queued note, oldest first, against the outputs
    initial begin
        forever begin
            @(chk_ev);
            while (q.size() > 0) begin
                nt = q.pop_front();
                check(name_of(nt.id), seen(nt.id) & nt.msk, nt.exp & nt.msk);
            end
        end
    end

    // watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        final_report();
    end

    // =========================================================
    // stimulus
    initial begin
        logic [7:0] d, x, w, e, m;
        int p;
        do_reset(1'h1, 1'h0);
        note(13, 8'h01, 8'hFF);
        note(1, 8'h70, 8'hFF);
        note(0, 8'h00, 8'h70);
        note(4, 8'h00, 8'hFF);
        note(7, 8'h00, 8'hFF);
        note(10, 8'h00, 8'hFF);
        settle();
        // general ports; bus inputs toggle and must be ignored here
        for (p = 1; p < 4; p++) begin
            rnd(d);
            rnd(w);
            rnd(x);
            @(posedge clk_in);
            ext[p * 8 +: 8] <= x;
            addr <= {~d, ~w}; // high byte is the inverse of the latch, so a second-port leak shows
            aph <= ~aph;
            wr(2 * p, d);
            wr(2 * p + 1, w);
            idle();
            note(3 * p, d, w);
            note(3 * p + 1, w, 8'hFF);
            note(3 * p + 2, (w & d) | (~w & x), 8'hFF);
            settle();
        end
        // open drain in single chip, board pull-up only
        rnd(d);
        @(posedge clk_in);
        ext_en[23:16] <= 8'h00;
        wr(REG_PIO_CTRL, 8'h20);
        wr(REG_THIRD_DIR, 8'hFF);
        wr(REG_THIRD_DATA, d);
        idle();
        note(7, ~d, 8'hFF);
        note(6, 8'h00, ~d);
        note(8, d, 8'hFF);
        settle();
        // first port directions from the pulse accumulator control
        rnd(d);
        rnd(x);
        @(posedge clk_in);
        ext[7:0] <= x;
        wr(REG_PULSE_ACCUM, 8'h88);
        wr(REG_FIRST_DATA, d);
        idle();
        note(1, 8'hF8, 8'hFF);
        note(0, d, 8'hF8);
        note(2, (d & 8'hF8) | (x & 8'h07), 8'hFF);
        settle();
        // compare owns bits 5 and 3; bit 0 cannot be claimed
        @(posedge clk_in);
        oc_en <= 8'h29;
        oc_lvl <= d;
        wr(REG_FIRST_DATA, ~d);
        idle();
        note(1, 8'hF8, 8'hFF);
        note(0, (~d & 8'hD0) | (d & 8'h28), 8'hF8);
        settle();
        // serial subsystems take some fourth-port bits
        rnd(d);
        rnd(e);
        rnd(w);
        rnd(x);
        m = {2'h3, (e[5:0] & w[5:0]) | ~e[5:0]};
        @(posedge clk_in);
        ser_en <= e[5:0];
        ser_oe <= w[5:0];
        ser_lvl <= x[5:0];
        wr(REG_FOURTH_DIR, 8'hFF);
        wr(REG_FOURTH_DATA, d);
        idle();
        note(10, m, 8'hFF);
        note(9, {d[7:6], (e[5:0] & x[5:0]) | (~e[5:0] & d[5:0])}, m);
        settle();
        // bootstrap: open drain has no effect
        do_reset(1'h0, 1'h0);
        note(13, 8'h04, 8'hFF);
        note(4, 8'h00, 8'hFF);
        settle();
        rnd(d);
        wr(REG_PIO_CTRL, 8'h20);
        wr(REG_THIRD_DIR, 8'hFF);
        wr(REG_THIRD_DATA, d);
        idle();
        note(7, 8'hFF, 8'hFF);
        note(6, d, 8'hFF);
        settle();
        // expanded then test: address, write and read phases
        for (p = 0; p < 2; p++) begin
            rnd(d);
            rnd(w);
            rnd(x);
            @(posedge clk_in);
            ext_en <= 32'hFFFFFFFF;
            ext[23:16] <= x;
            addr <= {d, w};
            aph <= 1'h1;
            rd <= 1'h0;
            wdata <= ~w;
            do_reset(~p[0], 1'h1);
            wr(REG_SECOND_DIR, 8'hFF);
            wr(REG_SECOND_DATA, ~d);
            wr(REG_FOURTH_DIR, 8'h00);
            wr(REG_FOURTH_DATA, 8'h80);
            idle();
            note(13, p ? 8'h08 : 8'h02, 8'hFF);
            note(4, 8'hFF, 8'hFF);
            note(3, d, 8'hFF);
            note(7, 8'hFF, 8'hFF);
            note(6, w, 8'hFF);
            note(10, 8'hC0, 8'hC0);
            note(9, 8'h40, 8'hC0);
            settle();
            @(posedge clk_in);
            aph <= 1'h0;
            note(6, ~w, 8'hFF);
            note(7, 8'hFF, 8'hFF);
            note(9, 8'h00, 8'hC0);
            settle();
            @(posedge clk_in);
            rd <= 1'h1;
            note(7, 8'h00, 8'hFF);
            note(12, x, 8'hFF);
            note(9, 8'h80, 8'hC0);
            settle();
        end
        final_report();
    end
endmodule // tb_top
